/* File: hdl/dio_map.vh */
// Register offsets, field positions and reset values of the dual I/O port.
`ifndef DIO_MAP_VH
`define DIO_MAP_VH
`define DIO_PORT_A_DATA_ADDR 28'h5FFFFC0
`define DIO_PORT_B_DATA_ADDR 28'h5FFFFC2
`define DIO_WORD_ADDR 28'h5FFFFC0
`define DIO_ADDR_W 28
`define DIO_DATA_RESET 16'h0000
`define DIO_MODE_TIMING_PATTERN 2'h3
`define DIO_PULLUP_BIT 3
`define DIO_PORT_A_LANE_LO 16
`define DIO_PORT_B_LANE_LO 0
`endif

/* File: hdl/dio_sync.v */
// Two-flip-flop synchroniser for a vector of pin levels.
module dio_sync #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;

  // Only the second stage reads the first; no logic looks at it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // dio_sync

/* File: hdl/dio_port.v */
// One 16-bit port: data register, write gating, pin drive and read mux.
module dio_port #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Software side
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] wr_mask,
  output wire [WIDTH-1:0] rd_value,
  // Pin control
  input wire [WIDTH-1:0] direction,
  input wire [WIDTH-1:0] ordinary_io,
  input wire [WIDTH-1:0] write_block,
  input wire [WIDTH-1:0] pin_level,
  // Pins
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe
);
  reg [WIDTH-1:0] data;
  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Bit i of the register belongs to pin i. [R3]
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          data[i] <= 1'b0; // [R9]
        end else if (wr_mask[i] && !write_block[i]) begin // [R8]
          data[i] <= wr_data[i]; // [R7]
        end
      end
      // Output register reads back, input reads the live pin. [R5] [R6]
      assign rd_value[i] = direction[i] ? data[i] : pin_level[i];
      // Only an ordinary output carries the register to the pin. [R4] [R7]
      assign pin_oe[i] = direction[i] & ordinary_io[i];
      assign pin_out[i] = data[i];
    end
  endgenerate
endmodule // dio_port

/* File: hdl/dio_top.v */
// APB slave holding the two 16-bit general-purpose port data registers.
//
// Notes on behaviour
// [R1] Port A data register, 16 bits, at 5FFFFC0, 8/16/32-bit access.
// [R2] Port B data register, 16 bits, at 5FFFFC2, 8/16/32-bit access.
// [R3] Register bit n belongs to port pin n.
// [R4] Direction 1 and ordinary output: pin drives the stored bit.
// [R5] Direction 1: reading returns the stored bit, whatever the pin.
// [R6] Direction 0: reading returns the live pin level.
// [R7] Not an ordinary output: writes store but leave the pin alone.
// [R8] Port B timing-pattern pin with next-data enable: writes ignored.
// [R9] Power-on reset clears both registers; other resets do not. Here every presetn assertion clears both.
// [R10] Bit-3 pull-up only as wait input and only when enabled.
// [R11] Pin functions come from the outside pin function controller.
// [R12] Port B mode field value 11 selects timing pattern output.
// [R13] Direction, function selects and enables come in as inputs.
module dio_top #(
  parameter WIDTH = 16
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Control from the pin function controller
  input wire [WIDTH-1:0] port_a_direction,
  input wire [WIDTH-1:0] port_b_direction,
  input wire [WIDTH-1:0] port_a_ordinary_io,
  input wire [WIDTH-1:0] port_b_ordinary_io,
  input wire [2*WIDTH-1:0] port_b_mode,
  input wire [WIDTH-1:0] pattern_next_data_enable,
  input wire port_a_bit3_wait_sel,
  input wire wait_pullup_enable,
  // Port A pins
  input wire [WIDTH-1:0] port_a_in,
  output wire [WIDTH-1:0] port_a_out,
  output wire [WIDTH-1:0] port_a_oe,
  output wire port_a_bit3_pullup,
  // Port B pins
  input wire [WIDTH-1:0] port_b_in,
  output wire [WIDTH-1:0] port_b_out,
  output wire [WIDTH-1:0] port_b_oe
);
`include "dio_map.vh"

  localparam [`DIO_ADDR_W-1:0] WORD_ADDR = `DIO_WORD_ADDR;

  wire [WIDTH-1:0] a_level;
  wire [WIDTH-1:0] b_level;
  wire [WIDTH-1:0] a_value;
  wire [WIDTH-1:0] b_value;
  wire [WIDTH-1:0] a_mask;
  wire [WIDTH-1:0] b_mask;
  wire [WIDTH-1:0] tp_sel;
  wire hit;
  wire do_write;
  reg [31:0] rdata;

  // Lane mask for one 16-bit half of the word, from two byte strobes.
  function [WIDTH-1:0] lane_mask;
    input [1:0] strobe;
    begin
      lane_mask = {{(WIDTH/2){strobe[1]}}, {(WIDTH/2){strobe[0]}}};
    end
  endfunction

  // Both ports share one aligned word: port A at the lower address sits in
  // the upper half, as on a big-endian bus, so byte lanes select the port.
  assign hit = (paddr[`DIO_ADDR_W-1:2] == WORD_ADDR[`DIO_ADDR_W-1:2]) &&
               (paddr[31:`DIO_ADDR_W] == 4'h0); // [R1] [R2]
  assign do_write = psel & penable & pwrite & hit;
  assign a_mask = do_write ? lane_mask(pstrb[3:2]) : {WIDTH{1'b0}}; // [R1]
  assign b_mask = do_write ? lane_mask(pstrb[1:0]) : {WIDTH{1'b0}}; // [R2]

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_tp
      // Mode 11 marks the pin as a timing pattern output. [R12]
      assign tp_sel[i] = (port_b_mode[2*i+1:2*i] ==
                          `DIO_MODE_TIMING_PATTERN) &
                         pattern_next_data_enable[i]; // [R8] [R13]
    end
  endgenerate

  // Pin levels come from outside the clock domain.
  dio_sync #(.WIDTH(WIDTH)) u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(port_a_in),
    .sync_out(a_level)
  );

  dio_sync #(.WIDTH(WIDTH)) u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(port_b_in),
    .sync_out(b_level)
  );

  // The function choice is made outside; this block only obeys it. [R11]
  dio_port #(.WIDTH(WIDTH)) u_port_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_data(pwdata[31:16]),
    .wr_mask(a_mask),
    .rd_value(a_value),
    .direction(port_a_direction),
    .ordinary_io(port_a_ordinary_io),
    .write_block({WIDTH{1'b0}}),
    .pin_level(a_level),
    .pin_out(port_a_out),
    .pin_oe(port_a_oe)
  );

  dio_port #(.WIDTH(WIDTH)) u_port_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_data(pwdata[15:0]),
    .wr_mask(b_mask),
    .rd_value(b_value),
    .direction(port_b_direction),
    .ordinary_io(port_b_ordinary_io),
    .write_block(tp_sel),
    .pin_level(b_level),
    .pin_out(port_b_out),
    .pin_oe(port_b_oe)
  );

  // Pull-up exists only for the wait function, never for I/O or select.
  assign port_a_bit3_pullup = port_a_bit3_wait_sel &
                              wait_pullup_enable; // [R10]

  // Read data is registered during setup so it is stable in access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite && hit) begin
      rdata <= {a_value, b_value}; // [R5] [R6]
    end else if (psel && !penable) begin
      rdata <= 32'h00000000;
    end
  end

  assign prdata = rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
endmodule // dio_top

/* File: verif/dio_monitor.sv */
// Assertions on the pin and bus ports of the dual I/O port block.
module dio_monitor (
  // Bus
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  // Pin control
  input logic [15:0] port_a_direction,
  input logic [15:0] port_a_ordinary_io,
  input logic [15:0] port_b_direction,
  input logic [15:0] port_b_ordinary_io,
  input logic [31:0] port_b_mode,
  input logic [15:0] pattern_next_data_enable,
  input logic port_a_bit3_wait_sel,
  input logic wait_pullup_enable,
  // Pins
  input logic [15:0] port_a_oe,
  input logic [15:0] port_a_out,
  input logic [15:0] port_b_oe,
  input logic [15:0] port_b_out,
  input logic port_a_bit3_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire hit = paddr[31:2] == 30'h017FFFF0;
  sequence s_wr;
    acc && pwrite && hit;
  endsequence
  chk_ready_high:
    assert property (psel |-> pready) else $error("pready low");
  chk_err_unmapped:
    assert property (acc |-> pslverr == !hit) else $error("pslverr wrong");
  chk_rd_unmapped:
    assert property (acc && !pwrite && !hit |-> prdata == 32'h00000000)
      else $error("unmapped read data");
  chk_a_update:
    assert property (s_wr ##0 pstrb[3:2] == 2'h3
      |=> port_a_out == $past(pwdata[31:16])) else $error("A not stored");
  chk_b_update:
    assert property (s_wr ##0 pstrb[1:0] == 2'h3 &&
      pattern_next_data_enable == 16'h0000
      |=> port_b_out == $past(pwdata[15:0])) else $error("B not stored");
  chk_b_blocked:
    assert property (s_wr ##0 pstrb[0] && port_b_mode[1:0] == 2'h3 &&
      pattern_next_data_enable[0] |=> $stable(port_b_out[0]))
      else $error("blocked bit written");
  chk_a_hold:
    assert property (!(acc && pwrite && hit) |=> $stable(port_a_out))
      else $error("A changed without write");
  chk_oe_map:
    assert property (port_a_oe == (port_a_direction & port_a_ordinary_io))
      else $error("A enable wrong");
  chk_b_oe_map:
    assert property (port_b_oe == (port_b_direction & port_b_ordinary_io))
      else $error("B enable wrong");
  chk_pullup_sel:
    assert property (port_a_bit3_pullup ==
      (port_a_bit3_wait_sel && wait_pullup_enable)) else $error("pull-up");
endmodule // dio_monitor

/* File: verif/dio_pins.sv */
// Board model of one port's pins.
module dio_pins (
  // Block side
  input logic [15:0] out,
  input logic [15:0] oe,
  // Board side
  input logic [15:0] board,
  output logic [15:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin shows what the board applies, so stale data cannot hide.
  assign level = (oe & out) | (~oe & board);
endmodule // dio_pins

/* File: verif/dio_top_tb.sv */
// Bench for the dual I/O port block through its APB slave.
module dio_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] W = 32'h05FFFFC0;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic port_a_bit3_wait_sel = '0, wait_pullup_enable = '0, err;
  logic [31:0] paddr = '0, pwdata = '0, port_b_mode = '0, rd;
  logic [3:0] pstrb = '0;
  logic [15:0] port_a_direction = '0, port_b_direction = '0, ext_a = '0;
  logic [15:0] port_a_ordinary_io = '0, port_b_ordinary_io = '0;
  logic [15:0] pattern_next_data_enable = '0, ext_b = '0;
  wire [31:0] prdata;
  wire pready, pslverr, port_a_bit3_pullup;
  wire [15:0] port_a_in, port_a_out, port_a_oe;
  wire [15:0] port_b_in, port_b_out, port_b_oe;
  int bad_count = 0;
  int tests_run = 0;
  always #2.5 pclk = ~pclk;
  dio_top dut_u (.*);
  dio_pins pa_u (.out(port_a_out), .oe(port_a_oe), .board(ext_a),
    .level(port_a_in));
  dio_pins pb_u (.out(port_b_out), .oe(port_b_oe), .board(ext_b),
    .level(port_b_in));
  task automatic apb(input logic w, input logic [31:0] a, d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
    $display("test %s done", n);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #3000;
    bad_count++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    port_a_direction <= 16'hFFFF;
    port_b_direction <= 16'hFFFF;
    port_a_ordinary_io <= 16'hFFFF;
    port_b_ordinary_io <= 16'h00FF;
    apb(1'b0, W, '0, 4'h0);
    chk("reset", 32'h00000000, rd);
    apb(1'b1, W, 32'h1234ABCD, 4'hF);
    apb(1'b0, W, '0, 4'h0);
    chk("word", 32'h1234ABCD, rd);
    chk("pins", 32'h123400CD, {port_a_in, port_b_in});
    apb(1'b1, W, 32'h00550000, 4'h4);
    apb(1'b0, W, '0, 4'h0);
    chk("byte", 32'h1255ABCD, rd);
    port_a_direction <= 16'h0000;
    ext_a <= 16'hC3C3;
    apb(1'b1, W, 32'h0F0F0000, 4'hC);
    apb(1'b0, W, '0, 4'h0);
    chk("input", 32'hC3C3ABCD, rd);
    port_a_direction <= 16'hFFFF;
    port_b_mode <= 32'h0002FFFF;
    pattern_next_data_enable <= 16'h01FF;
    apb(1'b1, W, 32'h00001111, 4'h3);
    apb(1'b0, W, '0, 4'h0);
    chk("pattern", 32'h0F0F11CD, rd);
    port_b_direction <= 16'h00FF;
    ext_b <= 16'h5A00;
    apb(1'b1, W, 32'h0000EE00, 4'h2);
    apb(1'b0, W, '0, 4'h0);
    chk("b input", 32'h0F0F5ACD, rd);
    apb(1'b1, W + 32'h4, 32'hFFFFFFFF, 4'hF);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b0, W + 32'h4, '0, 4'h0);
    chk("unmapped read", 32'h00000000, rd);
    apb(1'b0, W, '0, 4'h0);
    chk("unmapped", 32'h0F0F5ACD, rd);
    presetn <= 1'b0;
    port_b_direction <= 16'hFFFF;
    port_a_bit3_wait_sel <= 1'b1;
    wait_pullup_enable <= 1'b1;
    @(posedge pclk);
    presetn <= 1'b1;
    chk("pullup", 32'h1, {31'h0, port_a_bit3_pullup});
    apb(1'b0, W, '0, 4'h0);
    chk("reset again", 32'h00000000, rd);
    conclude;
  end
endmodule // dio_top_tb
bind dio_top dio_monitor chk_u (.*);
